// ### diag_led_asserts.sv
// Concurrent property checker for the diagnostic indicator controller
`timescale 1ns/100ps
`default_nettype none
module diag_led_asserts #(
  parameter int MEM_SOCKETS = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire diag_led_pkg::cond_s condPins,
  input wire logic [MEM_SOCKETS-1:0] memPresent,
  input wire diag_led_pkg::bus_req_s busReq,
  input wire logic standbyIndicator,
  input wire logic [2:0] fanFaultLed,
  input wire logic [MEM_SOCKETS-1:0] memoryModuleFaultLed,
  input wire logic statusGreen,
  input wire logic statusAmber,
  input wire logic [7:0] progressLed
);
  // Edges since reset release, so $past never looks into reset
  logic [2:0] upCnt;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      upCnt <= 3'h0;
    end else if (upCnt != 3'h7) begin
      upCnt <= upCnt + 3'h1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  standby_led_a: assert property (upCnt > 3'h4 |->
    standbyIndicator == $past(condPins.acPresent & condPins.standbyOk, 3)) else $error("standby led wrong");
  fan_led_a: assert property (upCnt > 3'h4 |-> fanFaultLed == $past(condPins.fanFault, 3))
    else $error("fan led wrong");
  mem_led_a: assert property (upCnt > 3'h4 |-> (memoryModuleFaultLed & ~$past(memPresent, 3)) == '0)
    else $error("empty socket led lit");
  boot_amber_a: assert property (upCnt == 3'h2 |-> statusAmber && !statusGreen)
    else $error("no amber after reset");
  fatal_amber_a: assert property (upCnt > 3'h5 &&
    $past(condPins.thermalTrip && condPins.acPresent && condPins.sysPowered, 4) |-> statusAmber && !statusGreen)
    else $error("fatal not solid amber");
  colour_excl_a: assert property (!(statusGreen && statusAmber))
    else $error("both colours lit");
  progress_hold_a: assert property (upCnt > 3'h1 && !$past(busReq.wr) |-> $stable(progressLed))
    else $error("progress changed without write");
  no_ac_a: assert property (upCnt > 3'h5 && !$past(condPins.acPresent, 4) |-> !statusGreen)
    else $error("green without ac");
endmodule
bind diagnostic_led_controller diag_led_asserts #(.MEM_SOCKETS(MEM_SOCKETS)) i_diag_led_asserts (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .condPins(condPins), .memPresent(memPresent), .busReq(busReq),
  .standbyIndicator(standbyIndicator), .fanFaultLed(fanFaultLed), .memoryModuleFaultLed(memoryModuleFaultLed),
  .statusGreen(statusGreen), .statusAmber(statusAmber), .progressLed(progressLed));
`default_nettype wire

// ### diag_led_pkg.sv
// Constants, carriers and state codes for the diagnostic indicator controller
// Functional notes
// - Standby indicator lit while AC present and standby rail supplied, even system off.
// - One fault indicator per fan (two processor fans, rear fan 5) follows its fault.
// - Each identify button press toggles identify indicator between solid blue and off.
// - Identify command blinks indicator for 15 s, or until a later command clears it.
// - Status solid green when booted, ready and no fault asserted.
// - Status blinks green for non-critical thresholds, predictive failure, redundancy lost on redundant systems.
// - Over 10 correctable errors plus mirroring gives blinking green and affected memory indicator.
// - Status blinks amber on critical thresholds, catastrophic error, regulator hot, interrupt timeout.
// - Status solid amber on fatal conditions, including insufficient redundancy on redundant systems.
// - Status solid amber while the management controller is still booting after AC.
// - Status off when AC absent; when system down, off unless a condition is held.
// - At power-down keep the prior status, but solid green turns off.
// - Memory fault indicator lights only for a populated socket with an error, or in the mirror mask during migration.
// - Progress indicators hold the last written code until the next write.
package diag_led_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] IDENT_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] PROGRESS_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] INT_STAT_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] INT_MASK_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] MIRROR_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] MEMFAULT_OFS = 8'h1C;

  // CTRL fields
  localparam int CTRL_MGMT_READY_BIT = 0;
  localparam int CTRL_BOOT_DONE_BIT = 1;
  localparam int CTRL_REDUNDANT_BIT = 2;
  // IDENT fields
  localparam int IDENT_ON_BIT = 0;
  localparam int IDENT_FOREVER_BIT = 1;
  // STATUS fields
  localparam int STAT_CODE_LSB = 0;
  localparam int STAT_ID_LSB = 4;
  localparam int STAT_FAN_LSB = 8;
  localparam int STAT_CORR_LSB = 16;
  // Interrupt bits
  localparam int INT_STATUS_CHG = 0;
  localparam int INT_BUTTON = 1;
  localparam int INT_ID_EXPIRED = 2;
  localparam int INT_FAN_FAULT = 3;
  localparam int INT_MEM_FAULT = 4;
  localparam int INT_W = 5;

  localparam logic [INT_W-1:0] INT_MASK_RST = 5'h00;
  localparam logic [7:0] PROGRESS_RST = 8'h00;
  localparam logic [2:0] CTRL_RST = 3'h0;

  localparam logic [7:0] CORR_ERR_LIMIT = 8'h0A;

  localparam longint CLK_HZ = 40_000_000;
  localparam longint BLINK_HALF_MS = 500;
  localparam longint ID_TIMEOUT_S = 15;
  localparam int unsigned BLINK_HALF_CYC = int'(BLINK_HALF_MS * CLK_HZ / 1000);
  localparam int unsigned ID_TIMEOUT_CYC = int'(ID_TIMEOUT_S * CLK_HZ);

  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_GREEN = 3'h1,
    ST_BLINK_GREEN = 3'h3,
    ST_BLINK_AMBER = 3'h2,
    ST_AMBER = 3'h6
  } status_e;

  typedef enum logic [1:0] {
    ID_OFF = 2'h0,
    ID_SOLID = 2'h1,
    ID_BLINK_TIMED = 2'h3,
    ID_BLINK_FOREVER = 2'h2
  } ident_e;

  typedef struct packed {
    logic acPresent;
    logic standbyOk;
    logic sysPowered;
    logic idButton;
    logic corrErrEvent;
    logic mirrorActive;
    logic [2:0] fanFault;
    logic nonCritTemp;
    logic nonCritVolt;
    logic nonCritFan;
    logic fanRedLostOk;
    logic psuPredFail;
    logic psuRedLostOk;
    logic critTemp;
    logic catastrophicErrorFlag;
    logic critVolt;
    logic regulatorOverheatFlag;
    logic mgmtInterruptTimeout;
    logic cpuMissing;
    logic thermalTrip;
    logic nonRecovTemp;
    logic nonRecovVolt;
    logic powerFault;
    logic fanRedLostBad;
    logic psuRedLostBad;
  } cond_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

endpackage

// ### diagnostic_led_controller.sv
// Diagnostic indicator controller with register port and interrupt
`timescale 1ns/100ps
`default_nettype none
module diagnostic_led_controller #(
  parameter int MEM_SOCKETS = 8,
  parameter int unsigned BLINK_HALF_CYC = diag_led_pkg::BLINK_HALF_CYC,
  parameter int unsigned ID_TIMEOUT_CYC = diag_led_pkg::ID_TIMEOUT_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire diag_led_pkg::cond_s condPins,
  input wire logic [MEM_SOCKETS-1:0] memPresent,
  input wire logic [MEM_SOCKETS-1:0] memError,
  input wire diag_led_pkg::bus_req_s busReq,
  output logic [diag_led_pkg::DATA_W-1:0] rdata,
  output logic irq,
  output logic standbyIndicator,
  output logic [2:0] fanFaultLed,
  output logic [MEM_SOCKETS-1:0] memoryModuleFaultLed,
  output logic identifyLed,
  output logic statusGreen,
  output logic statusAmber,
  output logic [7:0] progressLed
);

  localparam int COND_W = $bits(diag_led_pkg::cond_s);
  localparam int RAW_W = COND_W + 2 * MEM_SOCKETS;

  if (MEM_SOCKETS < 1 || MEM_SOCKETS > 32) begin : gBadSockets
    $error("MEM_SOCKETS must be 1 to 32");
  end
  if (BLINK_HALF_CYC < 1 || ID_TIMEOUT_CYC < 1) begin : gBadTimes
    $error("Blink and identify counts must be at least 1");
  end

  // A timed identify shorter than one blink period would never visibly blink
  if (ID_TIMEOUT_CYC < 2 * BLINK_HALF_CYC) begin : gShortIdent
    $error("Identify timeout must cover at least one blink period");
  end

  typedef struct packed {
    logic [RAW_W-1:0] sync1;
    logic [RAW_W-1:0] sync2;
    logic btnPrev;
    logic corrPrev;
    logic poweredPrev;
    logic [7:0] corrCount;
    logic [31:0] blinkCnt;
    logic blinkOn;
    logic [31:0] idTimer;
    diag_led_pkg::ident_e idState;
    diag_led_pkg::status_e heldStatus;
    diag_led_pkg::status_e shown;
    logic [2:0] ctrl;
    logic [7:0] progress;
    logic [MEM_SOCKETS-1:0] mirrorMask;
    logic [diag_led_pkg::INT_W-1:0] intStat;
    logic [diag_led_pkg::INT_W-1:0] intMask;
    logic [diag_led_pkg::DATA_W-1:0] rdata;
    logic irq;
    logic standbyLed;
    logic [2:0] fanLed;
    logic [MEM_SOCKETS-1:0] memLed;
    logic idLed;
    logic green;
    logic amber;
  } state_s;

  state_s state_reg;
  state_s state_next;

  // Returns {green, amber} for a status code and blink phase
  function automatic logic [1:0] statusColour(input diag_led_pkg::status_e st, input logic ph);
    logic [1:0] col;
    col = 2'h0;
    unique case (st)
      diag_led_pkg::ST_OFF: col = 2'h0;
      diag_led_pkg::ST_GREEN: col = 2'h2;
      diag_led_pkg::ST_BLINK_GREEN: col = {ph, 1'b0};
      diag_led_pkg::ST_BLINK_AMBER: col = {1'b0, ph};
      diag_led_pkg::ST_AMBER: col = 2'h1;
      default: col = 2'h0;
    endcase
    return col;
  endfunction

  function automatic logic hit(input diag_led_pkg::bus_req_s r, input logic [diag_led_pkg::ADDR_W-1:0] ofs);
    return r.addr == ofs;
  endfunction

  always_comb begin
    state_s s;
    diag_led_pkg::cond_s c;
    logic [MEM_SOCKETS-1:0] pres;
    logic [MEM_SOCKETS-1:0] merr;
    logic press;
    logic idExpire;
    logic fatal;
    logic nonFatal;
    logic degraded;
    logic migrated;
    logic [1:0] col;
    logic [diag_led_pkg::INT_W-1:0] ev;
    logic [diag_led_pkg::INT_W-1:0] clr;
    diag_led_pkg::status_e live;
    diag_led_pkg::status_e shownNext;
    logic [diag_led_pkg::DATA_W-1:0] rd;
    s = state_reg;
    c = '0;
    pres = '0;
    merr = '0;
    press = 1'b0;
    idExpire = 1'b0;
    fatal = 1'b0;
    nonFatal = 1'b0;
    degraded = 1'b0;
    migrated = 1'b0;
    col = 2'h0;
    ev = '0;
    clr = '0;
    live = diag_led_pkg::ST_OFF;
    shownNext = diag_led_pkg::ST_OFF;
    rd = '0;

    // Only the second stage is ever read past this point
    s.sync1 = {condPins, memPresent, memError};
    s.sync2 = state_reg.sync1;
    c = diag_led_pkg::cond_s'(state_reg.sync2[RAW_W-1 -: COND_W]);
    pres = state_reg.sync2[2*MEM_SOCKETS-1:MEM_SOCKETS];
    merr = state_reg.sync2[MEM_SOCKETS-1:0];

    // Blink timebase shared by status and identify
    if (state_reg.blinkCnt >= BLINK_HALF_CYC - 1) begin
      s.blinkCnt = 32'h0;
      s.blinkOn = ~state_reg.blinkOn;
    end else begin
      s.blinkCnt = state_reg.blinkCnt + 32'h1;
    end

    // Correctable error count saturates rather than wrapping back under the limit
    if (c.corrErrEvent && !state_reg.corrPrev && state_reg.corrCount != 8'hFF) begin
      s.corrCount = state_reg.corrCount + 8'h1;
    end
    s.corrPrev = c.corrErrEvent;
    migrated = (state_reg.corrCount > diag_led_pkg::CORR_ERR_LIMIT) && c.mirrorActive;

    fatal = c.cpuMissing | c.thermalTrip | c.nonRecovTemp | c.nonRecovVolt | c.powerFault
      | (state_reg.ctrl[diag_led_pkg::CTRL_REDUNDANT_BIT] & (c.fanRedLostBad | c.psuRedLostBad));
    nonFatal = c.critTemp | c.catastrophicErrorFlag | c.critVolt | c.regulatorOverheatFlag
      | c.mgmtInterruptTimeout;
    degraded = c.nonCritTemp | c.nonCritVolt | c.nonCritFan | c.psuPredFail | migrated
      | (state_reg.ctrl[diag_led_pkg::CTRL_REDUNDANT_BIT] & (c.fanRedLostOk | c.psuRedLostOk));
    if (fatal) begin
      live = diag_led_pkg::ST_AMBER;
    end else if (nonFatal) begin
      live = diag_led_pkg::ST_BLINK_AMBER;
    end else if (degraded) begin
      live = diag_led_pkg::ST_BLINK_GREEN;
    end else if (state_reg.ctrl[diag_led_pkg::CTRL_BOOT_DONE_BIT]) begin
      live = diag_led_pkg::ST_GREEN;
    end else begin
      live = diag_led_pkg::ST_OFF;
    end

    s.poweredPrev = c.sysPowered;
    if (state_reg.poweredPrev && !c.sysPowered) begin
      s.heldStatus = (live == diag_led_pkg::ST_GREEN) ? diag_led_pkg::ST_OFF : live;
    end
    if (!state_reg.ctrl[diag_led_pkg::CTRL_MGMT_READY_BIT]) begin
      shownNext = diag_led_pkg::ST_AMBER;
    end else if (!c.acPresent) begin
      shownNext = diag_led_pkg::ST_OFF;
    end else if (!c.sysPowered) begin
      // Fresh snapshot used at once, so the fall cycle shows no stale colour
      shownNext = s.heldStatus;
    end else begin
      shownNext = live;
    end
    s.shown = shownNext;
    col = statusColour(state_reg.shown, state_reg.blinkOn);
    s.green = col[1];
    s.amber = col[0];

    // Button has no debounce here; the front panel is expected to deliver clean presses
    press = c.idButton & ~state_reg.btnPrev;
    s.btnPrev = c.idButton;
    idExpire = 1'b0;
    if (state_reg.idState == diag_led_pkg::ID_BLINK_TIMED) begin
      if (state_reg.idTimer >= ID_TIMEOUT_CYC - 1) begin
        s.idState = diag_led_pkg::ID_OFF;
        idExpire = 1'b1;
      end else begin
        s.idTimer = state_reg.idTimer + 32'h1;
      end
    end
    if (press) begin
      s.idState = (state_reg.idState == diag_led_pkg::ID_OFF) ? diag_led_pkg::ID_SOLID : diag_led_pkg::ID_OFF;
    end
    if (busReq.wr && hit(busReq, diag_led_pkg::IDENT_OFS)) begin
      s.idTimer = 32'h0;
      if (!busReq.wdata[diag_led_pkg::IDENT_ON_BIT]) begin
        s.idState = diag_led_pkg::ID_OFF;
      end else if (busReq.wdata[diag_led_pkg::IDENT_FOREVER_BIT]) begin
        s.idState = diag_led_pkg::ID_BLINK_FOREVER;
      end else begin
        s.idState = diag_led_pkg::ID_BLINK_TIMED;
      end
    end
    // Lamp lags the identify state by one edge, as every output is a flop
    unique case (state_reg.idState)
      diag_led_pkg::ID_OFF: s.idLed = 1'b0;
      diag_led_pkg::ID_SOLID: s.idLed = 1'b1;
      diag_led_pkg::ID_BLINK_TIMED: s.idLed = state_reg.blinkOn;
      diag_led_pkg::ID_BLINK_FOREVER: s.idLed = state_reg.blinkOn;
    endcase

    s.standbyLed = c.acPresent & c.standbyOk;
    s.fanLed = c.fanFault;
    // Mirror mask only counts once migration is in force
    s.memLed = pres & (merr | (migrated ? state_reg.mirrorMask : '0));

    // Register writes
    if (busReq.wr && hit(busReq, diag_led_pkg::CTRL_OFS)) begin
      s.ctrl = busReq.wdata[2:0];
    end
    if (busReq.wr && hit(busReq, diag_led_pkg::PROGRESS_OFS)) begin
      s.progress = busReq.wdata[7:0];
    end
    if (busReq.wr && hit(busReq, diag_led_pkg::INT_MASK_OFS)) begin
      s.intMask = busReq.wdata[diag_led_pkg::INT_W-1:0];
    end
    if (busReq.wr && hit(busReq, diag_led_pkg::MIRROR_OFS)) begin
      s.mirrorMask = busReq.wdata[MEM_SOCKETS-1:0];
    end

    // Events set after the clear so a coinciding event survives
    ev = '0;
    ev[diag_led_pkg::INT_STATUS_CHG] = shownNext != state_reg.shown;
    ev[diag_led_pkg::INT_BUTTON] = press;
    ev[diag_led_pkg::INT_ID_EXPIRED] = idExpire;
    ev[diag_led_pkg::INT_FAN_FAULT] = |(s.fanLed & ~state_reg.fanLed);
    ev[diag_led_pkg::INT_MEM_FAULT] = |(s.memLed & ~state_reg.memLed);
    clr = (busReq.wr && hit(busReq, diag_led_pkg::INT_STAT_OFS)) ? busReq.wdata[diag_led_pkg::INT_W-1:0] : '0;
    s.intStat = (state_reg.intStat & ~clr) | ev;
    s.irq = |(s.intStat & s.intMask);

    // Read data stands for the one cycle after the strobe only
    rd = '0;
    if (busReq.rd) begin
      if (hit(busReq, diag_led_pkg::CTRL_OFS)) begin
        rd[2:0] = state_reg.ctrl;
      end else if (hit(busReq, diag_led_pkg::IDENT_OFS)) begin
        rd[1:0] = state_reg.idState;
      end else if (hit(busReq, diag_led_pkg::PROGRESS_OFS)) begin
        rd[7:0] = state_reg.progress;
      end else if (hit(busReq, diag_led_pkg::STATUS_OFS)) begin
        rd[diag_led_pkg::STAT_CODE_LSB +: 3] = state_reg.shown;
        rd[diag_led_pkg::STAT_ID_LSB +: 2] = state_reg.idState;
        rd[diag_led_pkg::STAT_FAN_LSB +: 3] = state_reg.fanLed;
        rd[diag_led_pkg::STAT_CORR_LSB +: 8] = state_reg.corrCount;
      end else if (hit(busReq, diag_led_pkg::INT_STAT_OFS)) begin
        rd[diag_led_pkg::INT_W-1:0] = state_reg.intStat;
      end else if (hit(busReq, diag_led_pkg::INT_MASK_OFS)) begin
        rd[diag_led_pkg::INT_W-1:0] = state_reg.intMask;
      end else if (hit(busReq, diag_led_pkg::MIRROR_OFS)) begin
        rd[MEM_SOCKETS-1:0] = state_reg.mirrorMask;
      end else if (hit(busReq, diag_led_pkg::MEMFAULT_OFS)) begin
        rd[MEM_SOCKETS-1:0] = state_reg.memLed;
      end
    end
    s.rdata = rd;
    state_next = s;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // Named reset codes restated so a changed code cannot hide behind the zero fill
      state_reg <= '0;
      state_reg.ctrl <= diag_led_pkg::CTRL_RST;
      state_reg.progress <= diag_led_pkg::PROGRESS_RST;
      state_reg.intMask <= diag_led_pkg::INT_MASK_RST;
      state_reg.idState <= diag_led_pkg::ID_OFF;
      state_reg.shown <= diag_led_pkg::ST_OFF;
      state_reg.heldStatus <= diag_led_pkg::ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs come straight from the state flops
  assign rdata = state_reg.rdata;
  assign irq = state_reg.irq;
  assign standbyIndicator = state_reg.standbyLed;
  assign fanFaultLed = state_reg.fanLed;
  assign memoryModuleFaultLed = state_reg.memLed;
  assign identifyLed = state_reg.idLed;
  assign statusGreen = state_reg.green;
  assign statusAmber = state_reg.amber;
  assign progressLed = state_reg.progress;

endmodule
`default_nettype wire

// ### diagnostic_led_controller_tb.sv
// Self-checking bench for the diagnostic indicator controller
`timescale 1ns/100ps
`default_nettype none
module diagnostic_led_controller_tb;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic pressReq = 1'b0;
  diag_led_pkg::cond_s condWant = '0;
  diag_led_pkg::cond_s condPins, c, base;
  diag_led_pkg::bus_req_s busReq = '0;
  logic [7:0] presentWant = 8'h00;
  logic [7:0] errorWant = 8'h00;
  logic [7:0] memPresent, memError, memLed, progressLed;
  logic [31:0] rdata;
  logic [2:0] fanFaultLed;
  logic irq, standbyIndicator, identifyLed, statusGreen, statusAmber, lastId;
  int errTotal = 0;
  int checksDone = 0;
  int toggles;
  far_side_model i_far_side_model (.ref_clk(ref_clk), .pressReq(pressReq), .condWant(condWant),
    .presentWant(presentWant), .errorWant(errorWant), .condPins(condPins), .memPresent(memPresent),
    .memError(memError));
  diagnostic_led_controller #(.MEM_SOCKETS(8), .BLINK_HALF_CYC(4), .ID_TIMEOUT_CYC(50))
    i_diagnostic_led_controller (.ref_clk(ref_clk), .sys_rst(sys_rst), .condPins(condPins),
    .memPresent(memPresent), .memError(memError), .busReq(busReq), .rdata(rdata), .irq(irq),
    .standbyIndicator(standbyIndicator), .fanFaultLed(fanFaultLed), .memoryModuleFaultLed(memLed),
    .identifyLed(identifyLed), .statusGreen(statusGreen), .statusAmber(statusAmber), .progressLed(progressLed));
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    busReq.wr <= 1'b0;
  endtask
  task automatic rdx(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge ref_clk);
    busReq <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge ref_clk);
    busReq.rd <= 1'b0;
    @(negedge ref_clk);
    compare(what, exp, rdata & m);
  endtask
  task automatic settle(input diag_led_pkg::cond_s s);
    @(posedge ref_clk);
    condWant <= s;
    tick(6);
    @(negedge ref_clk);
  endtask
  task automatic press;
    @(posedge ref_clk);
    pressReq <= 1'b1;
    @(posedge ref_clk);
    pressReq <= 1'b0;
    tick(8);
    @(negedge ref_clk);
  endtask
  task automatic complete_run;
    if (errTotal == 0 && checksDone > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    tick(20000);
    errTotal++;
    complete_run();
  end
  initial begin
    tick(4);
    sys_rst <= 1'b0;
    tick(2);
    @(negedge ref_clk);
    compare("boot amber", 32'h1, 32'(statusAmber));
    rdx("status", diag_led_pkg::STATUS_OFS, 32'h7, 32'h6);
    wr(diag_led_pkg::CTRL_OFS, 32'h7);
    base = '0;
    base.acPresent = 1'b1;
    base.standbyOk = 1'b1;
    base.sysPowered = 1'b1;
    settle(base);
    compare("standby", 32'h1, 32'(standbyIndicator));
    rdx("status", diag_led_pkg::STATUS_OFS, 32'h7, 32'h1);
    compare("green", 32'h1, 32'(statusGreen));
    // Low 18 bits of the carrier: 0-6 fatal, 7-11 alarm, 12-17 degraded
    for (int i = 0; i < 18; i++) begin
      settle(base | (27'h1 << i));
      rdx("status", diag_led_pkg::STATUS_OFS, 32'h7, i < 7 ? 32'h6 : (i < 12 ? 32'h2 : 32'h3));
    end
    settle(base | 27'h20820);
    rdx("status", diag_led_pkg::STATUS_OFS, 32'h7, 32'h6);
    settle(base | 27'h20800);
    rdx("status", diag_led_pkg::STATUS_OFS, 32'h7, 32'h2);
    toggles = 0;
    lastId = statusAmber;
    repeat (20) begin
      @(negedge ref_clk);
      if (statusAmber !== lastId) toggles++;
      lastId = statusAmber;
    end
    compare("amber blink", 32'h5, 32'(toggles));
    wr(diag_led_pkg::CTRL_OFS, 32'h3);
    settle(base | 27'h4001);
    rdx("status", diag_led_pkg::STATUS_OFS, 32'h7, 32'h1);
    wr(diag_led_pkg::CTRL_OFS, 32'h7);
    c = base;
    c.sysPowered = 1'b0;
    settle(c);
    rdx("status", diag_led_pkg::STATUS_OFS, 32'h7, 32'h0);
    c = base;
    c.nonCritTemp = 1'b1;
    settle(c);
    c.sysPowered = 1'b0;
    settle(c);
    c.nonCritTemp = 1'b0;
    settle(c);
    rdx("status", diag_led_pkg::STATUS_OFS, 32'h7, 32'h3);
    c.acPresent = 1'b0;
    settle(c);
    rdx("status", diag_led_pkg::STATUS_OFS, 32'h7, 32'h0);
    compare("standby", 32'h0, 32'(standbyIndicator));
    wr(diag_led_pkg::INT_MASK_OFS, 32'h8);
    wr(diag_led_pkg::INT_STAT_OFS, 32'h1F);
    c = base;
    c.fanFault = 3'h5;
    settle(c);
    compare("fan led", 32'h5, 32'(fanFaultLed));
    compare("irq", 32'h1, 32'(irq));
    rdx("int stat", diag_led_pkg::INT_STAT_OFS, 32'h8, 32'h8);
    wr(diag_led_pkg::INT_MASK_OFS, 32'h0);
    tick(1);
    @(negedge ref_clk);
    compare("irq masked", 32'h0, 32'(irq));
    wr(diag_led_pkg::INT_STAT_OFS, 32'h1F);
    wr(diag_led_pkg::INT_MASK_OFS, 32'h8);
    tick(1);
    @(negedge ref_clk);
    compare("irq cleared", 32'h0, 32'(irq));
    @(posedge ref_clk);
    presentWant <= 8'h0F;
    errorWant <= 8'h33;
    settle(base);
    compare("mem led", 32'h3, 32'(memLed));
    rdx("mem reg", diag_led_pkg::MEMFAULT_OFS, 32'hFF, 32'h3);
    wr(diag_led_pkg::MIRROR_OFS, 32'h4);
    @(posedge ref_clk);
    errorWant <= 8'h00;
    c = base;
    c.mirrorActive = 1'b1;
    for (int k = 1; k < 12; k++) begin
      c.corrErrEvent = 1'b1;
      settle(c);
      c.corrErrEvent = 1'b0;
      settle(c);
      if (k == 10) rdx("status", diag_led_pkg::STATUS_OFS, 32'h7, 32'h1);
    end
    rdx("status", diag_led_pkg::STATUS_OFS, 32'h7, 32'h3);
    rdx("corr count", diag_led_pkg::STATUS_OFS, 32'hFF0000, 32'hB0000);
    compare("mem led", 32'h4, 32'(memLed));
    press();
    rdx("ident", diag_led_pkg::IDENT_OFS, 32'h3, 32'h1);
    compare("id led", 32'h1, 32'(identifyLed));
    press();
    rdx("ident", diag_led_pkg::IDENT_OFS, 32'h3, 32'h0);
    wr(diag_led_pkg::IDENT_OFS, 32'h1);
    rdx("ident", diag_led_pkg::IDENT_OFS, 32'h3, 32'h3);
    toggles = 0;
    lastId = identifyLed;
    repeat (20) begin
      @(negedge ref_clk);
      if (identifyLed !== lastId) toggles++;
      lastId = identifyLed;
    end
    compare("id blink", 32'h5, 32'(toggles));
    tick(40);
    rdx("ident", diag_led_pkg::IDENT_OFS, 32'h3, 32'h0);
    rdx("int stat", diag_led_pkg::INT_STAT_OFS, 32'h4, 32'h4);
    wr(diag_led_pkg::IDENT_OFS, 32'h3);
    tick(60);
    rdx("ident", diag_led_pkg::IDENT_OFS, 32'h3, 32'h2);
    wr(diag_led_pkg::IDENT_OFS, 32'h0);
    rdx("ident", diag_led_pkg::IDENT_OFS, 32'h3, 32'h0);
    wr(diag_led_pkg::PROGRESS_OFS, 32'h5A);
    wr(diag_led_pkg::PROGRESS_OFS, 32'hA5);
    tick(10);
    @(negedge ref_clk);
    compare("progress", 32'hA5, 32'(progressLed));
    rdx("progress", diag_led_pkg::PROGRESS_OFS, 32'hFF, 32'hA5);
    rdx("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire

// ### far_side_model.sv
// Sensor, button and memory pin model facing the indicator block
`timescale 1ns/100ps
`default_nettype none
module far_side_model (
  input wire logic ref_clk,
  input wire logic pressReq,
  input wire diag_led_pkg::cond_s condWant,
  input wire logic [7:0] presentWant,
  input wire logic [7:0] errorWant,
  output var diag_led_pkg::cond_s condPins,
  output wire logic [7:0] memPresent,
  output wire logic [7:0] memError
);
  // A press is held a few cycles, as a real button is never one edge
  logic [1:0] holdCnt = 2'h0;
  always @(posedge ref_clk) begin
    if (pressReq) begin
      holdCnt <= 2'h3;
    end else if (holdCnt != 2'h0) begin
      holdCnt <= holdCnt - 2'h1;
    end
  end
  always_comb begin
    condPins = condWant;
    condPins.idButton = holdCnt != 2'h0;
  end
  assign memPresent = presentWant;
  assign memError = errorWant;
endmodule
`default_nettype wire
